// *** hw/dor_defines.svh ***
// constants for the digital output routing block
`ifndef DOR_DEFINES_SVH
`define DOR_DEFINES_SVH

`define DOR_SRC_ONE 8'h00
`define DOR_SRC_ZERO 8'h01
`define DOR_SRC_ENC_LO 8'h02
`define DOR_SRC_ENC_HI 8'h08
`define DOR_SRC_POS_LO 8'h09
`define DOR_SRC_POS_HI 8'h0f
`define DOR_SRC_PWM 8'h10
`define DOR_SRC_PWM_INV 8'h11
`define DOR_ROUTE_OFF 16'hffff
`define DOR_ROUTE_RST 16'hffff
`define DOR_CTL_INV_BIT 7
`define DOR_FIRST_INDEX 8'h01
`define DOR_DIRECT_BASE 16
`define DOR_CLK_HZ 125000000
`define DOR_SWPWM_MAX_HZ 2000
`define DOR_OUT_MAX_HZ 500
`define DOR_HALF_CYC(f) ((`DOR_CLK_HZ + 2 * (f) - 1) / (2 * (f)))

`endif

// *** hw/dor_pkg.sv ***
// types shared by the digital output routing block
package dor_pkg;

    // one routing entry: source in the upper byte, control in the lower
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] ctl;
    } dor_route_t;

    // write port of the routing table
    typedef struct packed {
        logic en;
        logic [7:0] index;
        dor_route_t data;
    } dor_wr_t;

    // pulse shaper states
    typedef enum logic [2:0] {
        DOR_IDLE = 3'b001,
        DOR_HIGH = 3'b010,
        DOR_LOW = 3'b100
    } dor_pulse_state_t;

endpackage

// *** hw/dor_pulse.sv ***
// count follower: one paced output pulse per 2**shift count increments
`timescale 1ns/1ps
`default_nettype none
module dor_pulse
    import dor_pkg::*;
#(
    parameter int HALF_CYC = 62500,
    parameter int PEND_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    input wire logic [31:0] count,
    input wire logic [2:0] shift,
    output logic pulse_q
);
    logic [31:0] prev_q;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [31:0] delta;
    logic [31:0] mag;
    logic [31:0] add;
    logic [PEND_W-1:0] pend_q;
    logic [PEND_W:0] pend_sum;
    logic [31:0] timer_q;
    logic take;
    dor_pulse_state_t state_q;

    // both directions of travel count as increments
    always_comb begin
        delta = count - prev_q;
        mag = delta[31] ? (32'h0 - delta) : delta;
        acc_d = acc_q + mag;
        add = acc_d >> shift;
        take = (state_q == DOR_IDLE) && (pend_q != '0);
        pend_sum = {1'b0, pend_q} + {1'b0, add[PEND_W-1:0]};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q <= 32'h0;
        end else if (ce) begin
            prev_q <= count;
        end
    end

    // remainder survives between pulses so no increment is lost
    always_ff @(posedge clock) begin
        if (rst || (ce && clear)) begin
            acc_q <= 32'h0;
            pend_q <= '0;
        end else if (ce) begin
            acc_q <= acc_d & ((32'h1 << shift) - 32'h1);
            // saturate: a burst beyond what the pending counter holds is clipped
            if (pend_sum[PEND_W] || add[31:PEND_W] != '0) begin
                pend_q <= '1;
            end else begin
                pend_q <= pend_sum[PEND_W-1:0] - PEND_W'(take);
            end
        end
    end

    // each pulse holds high and low for a least half period
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= DOR_IDLE;
            timer_q <= 32'h0;
            pulse_q <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                DOR_IDLE: begin
                    if (take) begin
                        state_q <= DOR_HIGH;
                        timer_q <= 32'(HALF_CYC - 1);
                        pulse_q <= 1'b1;
                    end
                end
                DOR_HIGH: begin
                    if (timer_q == 32'h0) begin
                        state_q <= DOR_LOW;
                        timer_q <= 32'(HALF_CYC - 1);
                        pulse_q <= 1'b0;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                DOR_LOW: begin
                    if (timer_q == 32'h0) begin
                        state_q <= DOR_IDLE;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                default: begin
                    state_q <= DOR_IDLE;
                    pulse_q <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hw/dor_top.sv ***
// digital output routing: source select, control gating and pin drive
`timescale 1ns/1ps
`default_nettype none
`include "dor_defines.svh"
module dor_top
    import dor_pkg::*;
#(
    parameter int N_OUT = 3,
    parameter int SWPWM_HALF = `DOR_HALF_CYC(`DOR_SWPWM_MAX_HZ),
    parameter int OUT_HALF = `DOR_HALF_CYC(`DOR_OUT_MAX_HZ)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire dor_wr_t route_wr,
    input wire logic [7:0] route_rd_index,
    output dor_route_t route_rd_q,
    output logic route_rd_ok_q,
    input wire logic [31:0] output_control_word,
    input wire logic routing_enable,
    input wire logic [31:0] direct_polarity,
    input wire logic [31:0] direct_manual_en,
    input wire logic [31:0] direct_manual_val,
    input wire logic [31:0] enc_count,
    input wire logic [31:0] pos_actual,
    input wire logic brake_pwm,
    output logic [N_OUT-1:0] out_level_q,
    output logic [N_OUT-1:0] out_oe_q,
    output logic [31:0] out_applied_q
);
    // routing table, entry 1 (slot 0) is the software PWM output
    dor_route_t route_q [N_OUT];
    logic [N_OUT-1:0] pulse;
    logic [N_OUT-1:0] clear_q;
    logic [N_OUT-1:0] routed;
    logic [N_OUT-1:0] direct;
    logic [N_OUT-1:0] level_d;
    logic [31:0] applied_d;
    logic [7:0] wr_slot;
    logic [7:0] rd_slot;
    logic wr_hit;
    logic rd_hit;

    // table indices start at one; a bad index is ignored silently
    always_comb begin
        wr_slot = route_wr.index - `DOR_FIRST_INDEX;
        wr_hit = route_wr.en && (route_wr.index >= `DOR_FIRST_INDEX)
            && (wr_slot < 8'(N_OUT));
    end

    // a read of index 0 or past the last output is refused
    always_comb begin
        rd_slot = route_rd_index - `DOR_FIRST_INDEX;
        rd_hit = (route_rd_index >= `DOR_FIRST_INDEX)
            && (rd_slot < 8'(N_OUT));
    end

    // one slice per output: table entry, follower, gate and direct path
    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : gen_out
            logic is_enc;
            logic is_pos;
            logic [31:0] cnt;
            logic [2:0] shift;
            logic [4:0] ctl_bit;
            logic ctl_on;
            logic sig;
            dor_route_t r;

            // table entry: disabled until software fills it
            always_ff @(posedge clock) begin
                if (rst) begin
                    route_q[g] <= `DOR_ROUTE_RST;
                end else if (ce && wr_hit && wr_slot == 8'(g)) begin
                    route_q[g] <= route_wr.data;
                end
            end

            // divider restarts one cycle after a rewrite, once the new
            // source feeds the follower; clearing in the write cycle would
            // take the jump between two count sources as travel
            always_ff @(posedge clock) begin
                if (rst) begin
                    clear_q[g] <= 1'b0;
                end else if (ce) begin
                    clear_q[g] <= wr_hit && (wr_slot == 8'(g));
                end
            end

            always_comb begin
                r = route_q[g];
                is_enc = (r.src >= `DOR_SRC_ENC_LO)
                    && (r.src <= `DOR_SRC_ENC_HI);
                is_pos = (r.src >= `DOR_SRC_POS_LO)
                    && (r.src <= `DOR_SRC_POS_HI);
                cnt = is_pos ? pos_actual : enc_count;
                if (is_pos) begin
                    shift = 3'(r.src - `DOR_SRC_POS_LO);
                end else if (is_enc) begin
                    shift = 3'(r.src - `DOR_SRC_ENC_LO);
                end else begin
                    shift = 3'h0;
                end
            end

            // the pin limit differs between the software PWM and the rest;
            // a burst beyond 65535 pending pulses is clipped, not queued
            dor_pulse #(
                .HALF_CYC(g == 0 ? SWPWM_HALF : OUT_HALF),
                .PEND_W(16)
            ) u_pulse (
                .clock(clock),
                .rst(rst),
                .ce(ce),
                .clear(clear_q[g]),
                .count(cnt),
                .shift(shift),
                .pulse_q(pulse[g])
            );

            // gate by the control word; ctl bits 6:5 are ignored
            always_comb begin
                ctl_bit = r.ctl[4:0];
                ctl_on = output_control_word[ctl_bit]
                    ^ r.ctl[`DOR_CTL_INV_BIT];
            end

            // source choice; codes past the inverse PWM drive zero
            always_comb begin
                unique case (r.src)
                    `DOR_SRC_ONE: sig = 1'b1;
                    `DOR_SRC_ZERO: sig = 1'b0;
                    `DOR_SRC_PWM: sig = brake_pwm;
                    `DOR_SRC_PWM_INV: sig = ~brake_pwm;
                    default: begin
                        // count sources follow the paced pulse train
                        sig = (is_enc || is_pos) ? pulse[g] : 1'b0;
                    end
                endcase
                if ({r.src, r.ctl} == `DOR_ROUTE_OFF) begin
                    routed[g] = 1'b0;
                end else begin
                    routed[g] = sig & ctl_on;
                end
            end

            // direct mode: output n follows bit 15+n, software PWM bit 0
            always_comb begin
                int b;
                b = (g == 0) ? 0 : (`DOR_DIRECT_BASE + g - 1);
                if (direct_manual_en[b]) begin
                    direct[g] = direct_manual_val[b];
                end else begin
                    direct[g] = output_control_word[b] ^ direct_polarity[b];
                end
            end
        end
    endgenerate

    // routing mode overrides every direct setting while enabled;
    // outputs past bit 31 of the applied pattern are not shown there
    always_comb begin
        level_d = routing_enable ? routed : direct;
        applied_d = 32'h0;
        for (int i = 0; i < N_OUT; i++) begin
            if (i == 0) begin
                applied_d[0] = level_d[0];
            end else if (`DOR_DIRECT_BASE + i - 1 < 32) begin
                applied_d[`DOR_DIRECT_BASE + i - 1] = level_d[i];
            end
        end
    end

    // pin level register; bit 0 is the software PWM output
    always_ff @(posedge clock) begin
        if (rst) begin
            out_level_q <= '0;
        end else if (ce) begin
            out_level_q <= level_d;
        end
    end

    // pins are open drain: the driver pulls low for a logical zero,
    // so the enable is high exactly while the level is zero
    always_ff @(posedge clock) begin
        if (rst) begin
            out_oe_q <= '1;
        end else if (ce) begin
            out_oe_q <= ~level_d;
        end
    end

    // applied pattern in control word bit order, for software to read
    always_ff @(posedge clock) begin
        if (rst) begin
            out_applied_q <= 32'h0;
        end else if (ce) begin
            out_applied_q <= applied_d;
        end
    end

    // read port reports whether last cycle's index was valid
    always_ff @(posedge clock) begin
        if (rst) begin
            route_rd_ok_q <= 1'b0;
        end else if (ce) begin
            route_rd_ok_q <= rd_hit;
        end
    end

    // read data is a registered copy of the addressed entry, zero if refused
    always_ff @(posedge clock) begin
        if (rst) begin
            route_rd_q <= '0;
        end else if (ce) begin
            if (rd_hit) begin
                route_rd_q <= route_q[rd_slot[$clog2(N_OUT+1)-1:0]];
            end else begin
                route_rd_q <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/dor_load.sv ***
// pull-up loads hanging on the open-drain output pins
`timescale 1ns/1ps
`default_nettype none
module dor_load
    import dor_pkg::*;
#(
    parameter int N = 3
) (
    input wire logic [N-1:0] oe,
    output logic [N-1:0] pin
);
    // a released line floats up to the pull-up level
    assign pin = ~oe;
endmodule
`default_nettype wire

// *** tb/dor_top_sva.sv ***
// assertion checker for the output routing block
`timescale 1ns/1ps
`default_nettype none
module dor_top_sva
    import dor_pkg::*;
#(
    parameter int N_OUT = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire dor_wr_t route_wr,
    input wire logic [7:0] route_rd_index,
    input wire dor_route_t route_rd_q,
    input wire logic route_rd_ok_q,
    input wire logic [31:0] output_control_word,
    input wire logic routing_enable,
    input wire logic [31:0] direct_polarity,
    input wire logic [31:0] direct_manual_en,
    input wire logic [31:0] direct_manual_val,
    input wire logic brake_pwm,
    input wire logic [N_OUT-1:0] out_level_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [15:0] sh1_q;
    logic gate1;
    logic pwm1;
    logic drv1;
    // shadow of entry 2 only, to keep the checker small
    always_ff @(posedge clock) begin
        if (rst)
            sh1_q <= 16'hffff;
        else if (ce && route_wr.en && route_wr.index == 8'h02)
            sh1_q <= route_wr.data;
    end
    // expected levels of output 1
    assign gate1 = output_control_word[sh1_q[4:0]] ^ sh1_q[7];
    assign pwm1 = gate1 & (brake_pwm ^ sh1_q[8]);
    assign drv1 = direct_manual_en[16] ? direct_manual_val[16]
        : output_control_word[16] ^ direct_polarity[16];
    chk_rd_bad_idx: assert property (ce && (route_rd_index == 8'h00 ||
        route_rd_index > N_OUT) |=> !route_rd_ok_q && route_rd_q == 16'h0)
        else $error("bad index read not refused");
    chk_rd_good_idx: assert property (ce && route_rd_index != 8'h00 &&
        route_rd_index <= N_OUT |=> route_rd_ok_q)
        else $error("good index read refused");
    chk_wr_seen: assert property (ce && route_wr.en &&
        route_wr.index == 8'h02 ##1 ce && !route_wr.en &&
        route_rd_index == 8'h02 |=> route_rd_q == sh1_q)
        else $error("written entry not read back");
    chk_const_one: assert property (ce && routing_enable &&
        sh1_q[15:8] == 8'h00 |=> out_level_q[1] == $past(gate1))
        else $error("constant one source wrong");
    chk_const_zero: assert property (ce && routing_enable &&
        sh1_q[15:8] == 8'h01 |=> !out_level_q[1])
        else $error("constant zero source wrong");
    chk_route_off: assert property (ce && routing_enable &&
        sh1_q == 16'hffff |=> !out_level_q[1])
        else $error("disabled route drives output");
    chk_brake_pwm: assert property (ce && routing_enable &&
        sh1_q[15:9] == 7'h08 |=> out_level_q[1] == $past(pwm1))
        else $error("brake pwm routing wrong");
    // six matches the half period the bench instantiates
    chk_pulse_width: assert property ($rose(out_level_q[1]) &&
        routing_enable && sh1_q[15:8] inside {[8'h02:8'h0f]}
        |-> out_level_q[1] [*6])
        else $error("count pulse too short");
    chk_direct_mode: assert property (ce && !routing_enable
        |=> out_level_q[1] == $past(drv1))
        else $error("direct mode output wrong");
endmodule
bind dor_top dor_top_sva #(.N_OUT(N_OUT)) i_dor_top_sva (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .route_wr(route_wr),
    .route_rd_index(route_rd_index),
    .route_rd_q(route_rd_q),
    .route_rd_ok_q(route_rd_ok_q),
    .output_control_word(output_control_word),
    .routing_enable(routing_enable),
    .direct_polarity(direct_polarity),
    .direct_manual_en(direct_manual_en),
    .direct_manual_val(direct_manual_val),
    .brake_pwm(brake_pwm),
    .out_level_q(out_level_q)
);
`default_nettype wire

// *** tb/tb_dor_top.sv ***
// self-checking bench for the output routing block
`timescale 1ns/1ps
`default_nettype none
module tb_dor_top
    import dor_pkg::*;
();
    logic clock, rst, ce, routing_enable, brake_pwm, route_rd_ok_q;
    dor_wr_t route_wr;
    dor_route_t route_rd_q;
    logic [7:0] route_rd_index;
    logic [31:0] output_control_word, direct_polarity, direct_manual_en;
    logic [31:0] direct_manual_val, enc_count, pos_actual, out_applied_q;
    logic [2:0] out_level_q, out_oe_q, pin;
    int n_fail, comparisons, pulses;
    // rows: entry, low control byte, brake level, expected output 1
    logic [25:0] tab [9] = '{{16'h0005, 8'h20, 2'b01},
        {16'h0005, 8'h00, 2'b00}, {16'h0085, 8'h00, 2'b01},
        {16'h0185, 8'h00, 2'b00}, {16'hffff, 8'hff, 2'b00},
        {16'h1080, 8'h00, 2'b11}, {16'h1080, 8'h00, 2'b00},
        {16'h1180, 8'h00, 2'b10}, {16'h1180, 8'h01, 2'b00}};
    // short half periods keep pulse trains quick
    dor_top #(.N_OUT(3), .SWPWM_HALF(4), .OUT_HALF(6)) i_dor_top (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .route_wr(route_wr),
        .route_rd_index(route_rd_index),
        .route_rd_q(route_rd_q),
        .route_rd_ok_q(route_rd_ok_q),
        .output_control_word(output_control_word),
        .routing_enable(routing_enable),
        .direct_polarity(direct_polarity),
        .direct_manual_en(direct_manual_en),
        .direct_manual_val(direct_manual_val),
        .enc_count(enc_count),
        .pos_actual(pos_actual),
        .brake_pwm(brake_pwm),
        .out_level_q(out_level_q),
        .out_oe_q(out_oe_q),
        .out_applied_q(out_applied_q)
    );
    dor_load #(.N(3)) i_dor_load (.oe(out_oe_q), .pin(pin));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // count pulses seen on the output 1 pin
    always @(posedge pin[1]) pulses++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        @(posedge clock);
        route_wr <= {1'b1, i, d};
        @(posedge clock);
        route_wr.en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [15:0] d, input ok);
        @(posedge clock);
        route_rd_index <= i;
        tick(2);
        chk({route_rd_ok_q, route_rd_q}, {ok, d});
    endtask
    task automatic drv(input logic [31:0] w, input logic p);
        @(posedge clock);
        output_control_word <= w;
        brake_pwm <= p;
        tick(3);
    endtask
    task automatic conclude;
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog so a hang still ends in a verdict
    initial begin
        #200000;
        n_fail++;
        conclude;
    end
    initial begin
        {rst, ce, routing_enable, brake_pwm} = 4'b1100;
        {route_wr, route_rd_index} = '0;
        {output_control_word, direct_polarity, direct_manual_en} = '0;
        {direct_manual_val, enc_count, pos_actual} = '0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd(8'(i), (i inside {[1:3]}) ? 16'hffff : 16'h0, i inside {[1:3]});
        wr(8'h02, 16'h0405);
        rd(8'h02, 16'h0405, 1'b1);
        drv(32'h0001_0000, 1'b0);
        chk(out_level_q[1], 1'b1);
        @(posedge clock);
        direct_manual_en <= '1;
        tick(3);
        chk(out_level_q[1], 1'b0);
        @(posedge clock);
        routing_enable <= 1'b1;
        for (int i = 1; i < 4; i++)
            wr(8'(i), 16'h0005);
        drv(32'h20, 1'b0);
        chk(pin, 3'h7);
        chk(out_applied_q, 32'h0003_0001);
        foreach (tab[k]) begin
            wr(8'h02, tab[k][25:10]);
            drv({24'h0, tab[k][9:2]}, tab[k][1]);
            chk(out_level_q[1], tab[k][0]);
        end
        wr(8'h02, 16'h0405);
        drv(32'h20, 1'b0);
        pulses = 0;
        repeat (8) @(posedge clock) enc_count <= enc_count + 1;
        tick(60);
        chk(pulses, 2);
        wr(8'h02, 16'h0905);
        pulses = 0;
        repeat (3) @(posedge clock) pos_actual <= pos_actual + 1;
        tick(60);
        chk(pulses, 3);
        // frozen while the clock enable is low, caught up once it returns
        @(posedge clock);
        ce <= 1'b0;
        pos_actual <= pos_actual + 32'h5;
        pulses = 0;
        tick(20);
        chk(pulses, 0);
        @(posedge clock);
        ce <= 1'b1;
        tick(80);
        chk(pulses, 5);
        conclude;
    end
endmodule
`default_nettype wire
